// [hdl/psv_addr_gate.sv]
// decodes a program address against the implemented memory size
`timescale 1ns/1ps
`default_nettype none

module psv_addr_gate
  import psv_pkg::*;
(
  // address under test
  input  wire logic [20:0] i_addr,
  // memory size variant
  input  wire logic [1:0]  i_size,
  // decode results
  output logic             o_in_range,
  output logic [20:0]      o_cfg_base
);

  logic [20:0] top;

  // top of on-chip memory per variant; unknown codes fall to the largest part
  always_comb
  begin
    case (i_size)
      SIZE_8K:  top = TOP_8K;
      SIZE_16K: top = TOP_16K;
      SIZE_32K: top = TOP_32K;
      default:  top = TOP_32K;
    endcase
  end

  // setup words sit in the last eight bytes of on-chip memory
  assign o_in_range = (i_addr < top);       // RL2
  assign o_cfg_base = top - CFG_BYTES;      // RL9

endmodule
`default_nettype wire

// [hdl/psv_core.sv]
// program counter, vectors, zero fill and setup word copy for the core
// ----------------------------------------------------------------
// How it works
// [RL1] 21-bit program counter spans 2-Mbyte space
// [RL2] fetch above implemented memory returns zero
// [RL3] every reset loads program counter with 0000h
// [RL4] fixed vectors 0008h high, 0018h low
// [RL5] interrupt wake pushes PC, advances stack pointer
// [RL6] interrupt wake loads PC with matching vector
// [RL7] top four words copied to setup registers
// [RL8] bytes ascend, low byte first; fourth reserved
// [RL9] setup area 1FF8h/3FF8h/7FF8h by size
// [RL10] memory size selectable 8 to 32 Kbytes
// [RL11] separate program and data buses, concurrent
// [RL12] fetch held until setup copy completes
// ----------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module psv_core
  import psv_pkg::*;
(
  // clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_rst_b,
  // variant strap, caught while reset is held
  input  wire logic [1:0]         i_mem_size,
  // core control
  input  wire logic               i_fetch_req,
  input  wire logic               i_jump,
  input  wire logic [20:0]        i_jump_addr,
  input  wire logic               i_wake_irq,
  input  wire logic               i_wake_high,
  input  wire logic               i_high_priority_global_irq_enable,
  input  wire logic               i_low_priority_global_irq_enable,
  // core data side
  input  wire logic               i_data_req,
  input  wire logic               i_data_we,
  input  wire logic [11:0]        i_data_addr,
  input  wire logic [7:0]         i_data_wdata,
  // program memory port
  input  wire logic [15:0]        i_pmem_data,
  output logic                    o_pmem_rd,
  output logic [20:0]             o_pmem_addr,
  // data memory port
  output logic                    o_dmem_req,
  output logic                    o_dmem_we,
  output logic [11:0]             o_dmem_addr,
  output logic [7:0]              o_dmem_wdata,
  // instruction and program counter
  output logic                    o_fetch_ready,
  output logic                    o_instr_valid,
  output logic [15:0]             o_instr,
  output logic [20:0]             o_pc,
  // stack top and pointer
  output logic [7:0]              o_stack_top_upper_byte,
  output logic [7:0]              o_stack_top_high_byte,
  output logic [7:0]              o_stack_top_low_byte,
  output logic [4:0]              o_hardware_stack_pointer,
  // setup words
  output logic [15:0]             o_setup_word_one,
  output logic [15:0]             o_setup_word_two,
  output logic [15:0]             o_setup_word_three,
  output logic [15:0]             o_setup_word_four_reserved
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  psv_state_t   state_r,  state_nxt;
  logic [1:0]   size_r,   size_nxt;
  logic [20:0]  pc_r,     pc_nxt;
  logic [20:0]  tos_r,    tos_nxt;
  logic [4:0]   sp_r,     sp_nxt;
  logic [1:0]   idx_r,    idx_nxt;
  logic [1:0]   ridx_r,   ridx_nxt;
  logic         pend_r,   pend_nxt;
  logic         pcfg_r,   pcfg_nxt;
  logic         zpend_r,  zpend_nxt;
  logic         done_r,   done_nxt;
  logic         rd_r,     rd_nxt;
  logic [20:0]  addr_r,   addr_nxt;
  logic         ival_r,   ival_nxt;
  logic [15:0]  instr_r,  instr_nxt;
  logic [15:0]  cfg_r     [CFG_WORDS];
  logic [15:0]  cfg_nxt   [CFG_WORDS];
  logic         in_range;
  logic [20:0]  cfg_base;
  logic         wake_take;

  // decode of the current pc against the strapped size
  psv_addr_gate u_gate (
    .i_addr     (pc_r),
    .i_size     (size_r),
    .o_in_range (in_range),
    .o_cfg_base (cfg_base)
  );

  // wake only redirects when either global enable is set
  assign wake_take = i_wake_irq
                   & (i_high_priority_global_irq_enable | i_low_priority_global_irq_enable);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    size_nxt  = size_r;
    pc_nxt    = pc_r;
    tos_nxt   = tos_r;
    sp_nxt    = sp_r;
    idx_nxt   = idx_r;
    ridx_nxt  = ridx_r;
    pend_nxt  = 1'b0;
    pcfg_nxt  = pcfg_r;
    zpend_nxt = 1'b0;
    done_nxt  = done_r;
    rd_nxt    = 1'b0;
    addr_nxt  = addr_r;
    ival_nxt  = 1'b0;
    instr_nxt = instr_r;
    cfg_nxt   = cfg_r;
    // memory answers in the same cycle as the read strobe
    if (pend_r)
    begin
      if (pcfg_r)
        cfg_nxt[ridx_r] = i_pmem_data;       // RL7 RL8
      else
      begin
        instr_nxt = i_pmem_data;
        ival_nxt  = 1'b1;
      end
    end
    // beyond the implemented top no read is issued, a nop comes back
    if (zpend_r)
    begin
      instr_nxt = NOP_WORD;                  // RL2
      ival_nxt  = 1'b1;
    end
    case (state_r)
      ST_CFG:
      begin
        // one word per cycle, lowest address first
        rd_nxt   = 1'b1;
        addr_nxt = cfg_base + {18'h0_0000, idx_r, 1'b0};   // RL8 RL9
        pend_nxt = 1'b1;
        pcfg_nxt = 1'b1;
        ridx_nxt = idx_r;
        if (idx_r == CFG_LAST)
          state_nxt = ST_DRAIN;
        else
          idx_nxt = idx_r + 2'h1;
      end
      ST_DRAIN:
      begin
        // last word lands this cycle; fetch opens only afterwards
        state_nxt = ST_RUN;
        done_nxt  = 1'b1;                    // RL12
      end
      ST_RUN:
      begin
        if (wake_take)
        begin
          tos_nxt = pc_r;                    // RL5
          sp_nxt  = sp_r + 5'h01;            // RL5
          pc_nxt  = i_wake_high ? VEC_HIGH : VEC_LOW;   // RL4 RL6
        end
        else if (i_jump)
          pc_nxt = {i_jump_addr[20:1], 1'b0};
        else if (i_fetch_req)
        begin
          if (in_range)
          begin
            rd_nxt   = 1'b1;
            addr_nxt = pc_r;
            pend_nxt = 1'b1;
            pcfg_nxt = 1'b0;
          end
          else
            zpend_nxt = 1'b1;                // RL2
          pc_nxt = pc_r + PC_STEP;           // RL1
        end
      end
      default:
        state_nxt = ST_CFG;
    endcase
    // strap is tracked only while reset is held
    if (!i_rst_b)
      size_nxt = i_mem_size;                 // RL10
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock)
  begin
    size_r <= size_nxt;
    if (!i_rst_b)
    begin
      state_r <= ST_CFG;
      pc_r    <= VEC_RESET;                  // RL3
      tos_r   <= 21'h00_0000;
      sp_r    <= 5'h00;
      idx_r   <= 2'h0;
      ridx_r  <= 2'h0;
      pend_r  <= 1'b0;
      pcfg_r  <= 1'b0;
      zpend_r <= 1'b0;
      done_r  <= 1'b0;                       // RL12
      rd_r    <= 1'b0;
      addr_r  <= 21'h00_0000;
      ival_r  <= 1'b0;
      instr_r <= NOP_WORD;
      cfg_r   <= '{default: 16'h0000};
    end
    else
    begin
      state_r <= state_nxt;
      pc_r    <= pc_nxt;
      tos_r   <= tos_nxt;
      sp_r    <= sp_nxt;
      idx_r   <= idx_nxt;
      ridx_r  <= ridx_nxt;
      pend_r  <= pend_nxt;
      pcfg_r  <= pcfg_nxt;
      zpend_r <= zpend_nxt;
      done_r  <= done_nxt;
      rd_r    <= rd_nxt;
      addr_r  <= addr_nxt;
      ival_r  <= ival_nxt;
      instr_r <= instr_nxt;
      cfg_r   <= cfg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // data bus, registered on its own path
  // ----------------------------------------------------------------
  // never shares a strobe with the fetch port, so both run each cycle
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      o_dmem_req   <= 1'b0;
      o_dmem_we    <= 1'b0;
      o_dmem_addr  <= 12'h000;
      o_dmem_wdata <= 8'h00;
    end
    else
    begin
      o_dmem_req   <= i_data_req;            // RL11
      o_dmem_we    <= i_data_req & i_data_we;
      o_dmem_addr  <= i_data_addr;
      o_dmem_wdata <= i_data_wdata;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all taken from flops
  // ----------------------------------------------------------------
  assign o_pmem_rd                = rd_r;
  assign o_pmem_addr              = addr_r;
  assign o_fetch_ready            = done_r;
  assign o_instr_valid            = ival_r;
  assign o_instr                  = instr_r;
  assign o_pc                     = pc_r;
  assign o_stack_top_upper_byte   = {3'h0, tos_r[20:16]};
  assign o_stack_top_high_byte    = tos_r[15:8];
  assign o_stack_top_low_byte     = tos_r[7:0];
  assign o_hardware_stack_pointer = sp_r;
  assign o_setup_word_one         = cfg_r[0];
  assign o_setup_word_two         = cfg_r[1];
  assign o_setup_word_three       = cfg_r[2];
  assign o_setup_word_four_reserved = cfg_r[3];

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_run_fetch_out;
    state_r == ST_RUN && !wake_take && !i_jump && i_fetch_req && !in_range;
  endsequence

  // no read strobe one cycle on, the nop word the cycle after
  sequence s_zero_back;
    !o_pmem_rd ##1 (o_instr_valid && o_instr == NOP_WORD);
  endsequence

  property p_reset_pc;
    @(posedge i_clock) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> (o_pc == 21'h00_0000 && !o_fetch_ready);
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("pc not at reset vector"); // RL3

  property p_zero_fill;
    @(posedge i_clock) disable iff (!i_rst_b)
    s_run_fetch_out |=> s_zero_back;
  endproperty
  a_zero_fill: assert property (p_zero_fill) else $error("no nop above top"); // RL2

  property p_vec_high;
    @(posedge i_clock) disable iff (!i_rst_b)
    (state_r == ST_RUN && wake_take && i_wake_high) |=> o_pc == 21'h00_0008;
  endproperty
  a_vec_high: assert property (p_vec_high) else $error("bad high vector"); // RL6

  property p_vec_low;
    @(posedge i_clock) disable iff (!i_rst_b)
    (state_r == ST_RUN && wake_take && !i_wake_high) |=> o_pc == 21'h00_0018;
  endproperty
  a_vec_low: assert property (p_vec_low) else $error("bad low vector"); // RL4

  property p_push;
    @(posedge i_clock) disable iff (!i_rst_b)
    (state_r == ST_RUN && wake_take) |=>
      ({o_stack_top_upper_byte[4:0], o_stack_top_high_byte, o_stack_top_low_byte}
        == $past(o_pc)) && (o_hardware_stack_pointer == $past(o_hardware_stack_pointer) + 5'h01);
  endproperty
  a_push: assert property (p_push) else $error("stack not pushed"); // RL5

  property p_cfg_done;
    @(posedge i_clock) disable iff (!i_rst_b)
    $rose(i_rst_b) |-> !o_fetch_ready[*5] ##1 o_fetch_ready;
  endproperty
  a_cfg_done: assert property (p_cfg_done) else $error("setup copy timing"); // RL7

  property p_cfg_addr;
    @(posedge i_clock) disable iff (!i_rst_b)
    (o_pmem_rd && !o_fetch_ready) |->
      (o_pmem_addr >= cfg_base && o_pmem_addr < cfg_base + CFG_BYTES);
  endproperty
  a_cfg_addr: assert property (p_cfg_addr) else $error("setup read outside area"); // RL9

  property p_hold;
    @(posedge i_clock) disable iff (!i_rst_b)
    !o_fetch_ready |-> !o_instr_valid;
  endproperty
  a_hold: assert property (p_hold) else $error("fetch before setup copy"); // RL12

  property p_pc_step;
    @(posedge i_clock) disable iff (!i_rst_b)
    (state_r == ST_RUN && !wake_take && !i_jump && i_fetch_req) |=> o_pc == $past(o_pc) + PC_STEP;
  endproperty
  a_pc_step: assert property (p_pc_step) else $error("pc did not step"); // RL1

  property p_data_bus;
    @(posedge i_clock) disable iff (!i_rst_b)
    i_data_req |=> (o_dmem_req && o_dmem_addr == $past(i_data_addr));
  endproperty
  a_data_bus: assert property (p_data_bus) else $error("data access lost"); // RL11

endmodule
`default_nettype wire

// [hdl/psv_pkg.sv]
// shared constants for the program space, vector and setup word loader
package psv_pkg;

  // ----------------------------------------------------------------
  // address space
  // ----------------------------------------------------------------
  localparam int          PC_W      = 21;
  localparam int          WORD_W    = 16;
  localparam int          STK_W     = 5;
  localparam int          DADDR_W   = 12;
  localparam int          DATA_W    = 8;
  localparam logic [20:0] PC_STEP   = 21'h00_0002;
  localparam logic [15:0] NOP_WORD  = 16'h0000;

  // ----------------------------------------------------------------
  // fixed vectors
  // ----------------------------------------------------------------
  localparam logic [20:0] VEC_RESET = 21'h00_0000;
  localparam logic [20:0] VEC_HIGH  = 21'h00_0008;
  localparam logic [20:0] VEC_LOW   = 21'h00_0018;

  // ----------------------------------------------------------------
  // memory size variants and setup word area
  // ----------------------------------------------------------------
  localparam logic [1:0]  SIZE_8K   = 2'h0;
  localparam logic [1:0]  SIZE_16K  = 2'h1;
  localparam logic [1:0]  SIZE_32K  = 2'h2;
  localparam logic [20:0] TOP_8K    = 21'h00_2000;
  localparam logic [20:0] TOP_16K   = 21'h00_4000;
  localparam logic [20:0] TOP_32K   = 21'h00_8000;
  localparam logic [20:0] CFG_BYTES = 21'h00_0008;
  localparam int          CFG_WORDS = 4;
  localparam logic [1:0]  CFG_LAST  = 2'h3;

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_CFG,
    ST_DRAIN,
    ST_RUN
  } psv_state_t;

endpackage

// [testbench/test_program_space_vectors_config.sv]
// self-checking bench for the program space, vector and setup word loader
`timescale 1ns/1ps
`default_nettype none

module test_program_space_vectors_config;
  import psv_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        i_clock;
  logic        i_rst_b;
  logic [1:0]  i_mem_size;
  logic        i_fetch_req;
  logic        i_jump;
  logic [20:0] i_jump_addr;
  logic        i_wake_irq;
  logic        i_wake_high;
  logic        hi_en;
  logic        lo_en;
  logic        i_data_req;
  logic        i_data_we;
  logic [11:0] i_data_addr;
  logic [7:0]  i_data_wdata;
  logic [15:0] i_pmem_data;
  logic        o_pmem_rd;
  logic [20:0] o_pmem_addr;
  logic        o_dmem_req;
  logic        o_dmem_we;
  logic [11:0] o_dmem_addr;
  logic [7:0]  o_dmem_wdata;
  logic        o_fetch_ready;
  logic        o_instr_valid;
  logic [15:0] o_instr;
  logic [20:0] o_pc;
  logic [7:0]  o_tos_u;
  logic [7:0]  o_tos_h;
  logic [7:0]  o_tos_l;
  logic [4:0]  o_sp;
  logic [15:0] o_w1;
  logic [15:0] o_w2;
  logic [15:0] o_w3;
  logic [15:0] o_w4;
  int          miscompares;
  int          samples_checked;
  int          cycles;
  logic [31:0] rng;
  logic [31:0] drng;
  logic [1:0]  cur_size;
  logic        mon_on;
  logic [21:0] d_exp;

  psv_core dut (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_mem_size(i_mem_size),
    .i_fetch_req(i_fetch_req), .i_jump(i_jump), .i_jump_addr(i_jump_addr),
    .i_wake_irq(i_wake_irq), .i_wake_high(i_wake_high),
    .i_high_priority_global_irq_enable(hi_en), .i_low_priority_global_irq_enable(lo_en),
    .i_data_req(i_data_req), .i_data_we(i_data_we), .i_data_addr(i_data_addr),
    .i_data_wdata(i_data_wdata), .i_pmem_data(i_pmem_data), .o_pmem_rd(o_pmem_rd),
    .o_pmem_addr(o_pmem_addr), .o_dmem_req(o_dmem_req), .o_dmem_we(o_dmem_we),
    .o_dmem_addr(o_dmem_addr), .o_dmem_wdata(o_dmem_wdata),
    .o_fetch_ready(o_fetch_ready), .o_instr_valid(o_instr_valid), .o_instr(o_instr),
    .o_pc(o_pc), .o_stack_top_upper_byte(o_tos_u), .o_stack_top_high_byte(o_tos_h),
    .o_stack_top_low_byte(o_tos_l), .o_hardware_stack_pointer(o_sp),
    .o_setup_word_one(o_w1), .o_setup_word_two(o_w2), .o_setup_word_three(o_w3),
    .o_setup_word_four_reserved(o_w4)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // memory contents tied to address so every word is predictable
  function automatic logic [15:0] mem_word(input logic [20:0] a);
    return a[15:0] ^ 16'h3C5A ^ {a[20:16], 11'h000};
  endfunction

  // size 3 is read as the largest part
  function automatic logic [20:0] top_of(input logic [1:0] s);
    return (s == SIZE_8K) ? TOP_8K : (s == SIZE_16K) ? TOP_16K : TOP_32K;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // clock, timeout, program memory and data side
  // ----------------------------------------------------------------
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // generous ceiling, the sequence needs about a thousand cycles
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      miscompares++;
      print_verdict();
    end
  end

  // idle bus shows a changing value so a stale sample is caught
  always @(negedge i_clock)
    i_pmem_data <= (o_pmem_rd === 1'b1) ? mem_word(o_pmem_addr) : ~i_pmem_data;

  // expected data port copy, taken at the edge the design samples
  always @(posedge i_clock)
    d_exp = i_rst_b ? {i_data_req, i_data_we & i_data_req, i_data_addr, i_data_wdata} : '0;

  always @(negedge i_clock)
  begin
    if (mon_on)
      check({o_dmem_req, o_dmem_we, o_dmem_addr, o_dmem_wdata}, d_exp);
    drng = xs(drng);
    {i_data_req, i_data_we, i_data_addr, i_data_wdata} <= drng[21:0];
  end

  // ----------------------------------------------------------------
  // operations
  // ----------------------------------------------------------------
  task automatic reset_dut(input logic [1:0] s);
    logic [20:0] base;
    logic [20:0] a;
    int          k;
    int          n;
    base = top_of(s) - CFG_BYTES;
    k = 0;
    cur_size = s;
    i_rst_b = 1'b0;
    i_mem_size = s;
    repeat (6) @(negedge i_clock);
    check(o_pc, VEC_RESET);
    check(o_fetch_ready, 0);
    i_rst_b = 1'b1;
    i_fetch_req = 1'b1; // requests during the copy must be ignored
    for (n = 0; n < 12 && o_fetch_ready !== 1'b1; n++)
    begin
      @(negedge i_clock);
      if (o_fetch_ready !== 1'b1)
      begin
        check({o_pc, o_instr_valid}, 0);
      end
      if (o_pmem_rd === 1'b1)
      begin
        a = base + 21'(2 * k);
        check(o_pmem_addr, a);
        k++;
      end
    end
    i_fetch_req = 1'b0;
    check(k, CFG_WORDS);
    check(o_fetch_ready, 1);
    check({o_w1, o_w2}, {mem_word(base), mem_word(base + 21'h00_0002)});
    check({o_w3, o_w4}, {mem_word(base + 21'h00_0004), mem_word(base + 21'h00_0006)});
    check(o_pc, VEC_RESET);
    mon_on = 1'b1;
  endtask

  task automatic do_jump(input logic [20:0] a);
    i_jump = 1'b1;
    i_jump_addr = a;
    @(negedge i_clock);
    i_jump = 1'b0;
    check(o_pc, {a[20:1], 1'b0});
    // idle edge so a following request starts from a low strobe
    @(negedge i_clock);
  endtask

  task automatic do_fetch;
    logic [20:0] pc0;
    logic [20:0] nxt;
    logic        inr;
    int          n;
    pc0 = o_pc;
    nxt = pc0 + PC_STEP;
    inr = pc0 < top_of(cur_size);
    i_fetch_req = 1'b1;
    @(negedge i_clock);
    i_fetch_req = 1'b0;
    check(o_pc, nxt);
    check(o_pmem_rd, inr);
    if (inr)
      check(o_pmem_addr, pc0);
    for (n = 0; n < 4 && o_instr_valid !== 1'b1; n++)
      @(negedge i_clock);
    check(o_instr_valid, 1);
    check(o_instr, inr ? mem_word(pc0) : NOP_WORD);
  endtask

  task automatic do_wake(input logic hi, input logic eh, input logic el);
    logic [20:0] pc0;
    logic [4:0]  sp1;
    pc0 = o_pc;
    sp1 = o_sp + 5'h01;
    i_wake_high = hi;
    hi_en = eh;
    lo_en = el;
    i_wake_irq = 1'b1;
    @(negedge i_clock);
    i_wake_irq = 1'b0;
    if (eh | el)
    begin
      check(o_pc, hi ? VEC_HIGH : VEC_LOW);
      check({o_tos_u, o_tos_h, o_tos_l, o_sp}, {3'b000, pc0, sp1});
    end
    else
      check({o_pc, o_sp}, {pc0, sp1 - 5'h01});
    // idle edge so back to back wakes never retoggle the strobe at once
    @(negedge i_clock);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {i_rst_b, i_mem_size, i_fetch_req, i_jump, i_jump_addr} = '0;
    {i_wake_irq, i_wake_high, hi_en, lo_en, i_pmem_data} = '0;
    {i_data_req, i_data_we, i_data_addr, i_data_wdata} = '0;
    {miscompares, samples_checked, cycles, mon_on} = '0;
    rng = 32'h0000_A7F8;
    drng = 32'h0000_A7F8;
    d_exp = '0;
    // every size, each reset after the first in mid-run, boundary words and wrap of the space
    for (int s = 0; s < 4; s++)
    begin
      reset_dut(2'(s));
      do_jump(top_of(2'(s)) - 21'h00_0002);
      do_fetch(); // last implemented word
      do_fetch(); // first word above the top
      do_jump(21'h1F_FFFF);
      do_fetch();
      do_wake(1'b1, 1'b1, 1'b0);
      do_wake(1'b0, 1'b0, 1'b1);
      do_wake(1'b1, 1'b0, 1'b0);
    end
    // random mix, long enough for the stack pointer to wrap
    repeat (400)
    begin
      rng = xs(rng);
      case (rng[1:0])
        2'h0: do_jump(rng[3] ? rng[31:11] : {6'h00, rng[31:17]});
        2'h3: do_wake(rng[4], rng[5], rng[6]);
        default: do_fetch();
      endcase
    end
    print_verdict();
  end

endmodule

`default_nettype wire
